// >>> shared/bia_params.svh
// Offsets, field widths, reset values and timing counts of the brake and alarm block.
`ifndef BIA_PARAMS_SVH
`define BIA_PARAMS_SVH

// --------------------------------------------------------------------------
// Register offsets (byte addresses)
// --------------------------------------------------------------------------
`define BIA_CTRL_OFS 8'h00
`define BIA_STOP_DELAY_OFS 8'h04
`define BIA_SPEED_LEVEL_OFS 8'h08
`define BIA_WAIT_TIME_OFS 8'h0C
`define BIA_MAX_SPEED_OFS 8'h10
`define BIA_STATUS_OFS 8'h14

// --------------------------------------------------------------------------
// Field widths and reset values
// --------------------------------------------------------------------------
`define BIA_DELAY_W 6
`define BIA_SPEED_W 14
`define BIA_WAIT_W 7
`define BIA_CTRL_RST 6'h00
`define BIA_STOP_DELAY_RST 6'h00
`define BIA_STOP_DELAY_MAX 6'h32
`define BIA_SPEED_LEVEL_RST 14'h0064
`define BIA_MAX_SPEED_RST 14'h0BB8
`define BIA_WAIT_TIME_RST 7'h32
`define BIA_WAIT_TIME_MIN 7'h0A
`define BIA_WAIT_TIME_MAX 7'h64

// --------------------------------------------------------------------------
// Timing
// --------------------------------------------------------------------------
`define BIA_TICK_PERIOD_MS 10
`define BIA_CLK_PERIOD_NS 5
`define BIA_TICK_CYCLES ((`BIA_TICK_PERIOD_MS * 1000000) / `BIA_CLK_PERIOD_NS)

`endif

// >>> shared/bia_pkg.sv
// Types shared by the brake and alarm block.
package bia_pkg;

  typedef enum logic [1:0] {
    BIA_OFF = 2'b00,
    BIA_ON = 2'b01,
    BIA_STOPDLY = 2'b11,
    BIA_MOVE = 2'b10
  } bia_state_type;

  typedef struct packed {
    logic [1:0] aux1_sel;
    logic [1:0] aux0_sel;
    logic [1:0] brake_sel;
  } bia_ctrl_type;

  typedef struct packed {
    logic active;
    logic encoder;
    logic [2:0] code;
  } bia_fault_type;

endpackage : bia_pkg

// >>> logic/bia_tick.sv
// Restartable 10 ms timebase for the brake delay counters.
module bia_tick
  import bia_pkg::*;
#(
  parameter int TICK_CYCLES = 2000000
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic clr_i,
  output logic tick_o
);

  logic [31:0] cnt_q;
  logic [31:0] cnt_d;
  logic wrap;

  assign wrap = (cnt_q == 32'(TICK_CYCLES - 1));
  assign cnt_d = (clr_i || wrap) ? 32'h0000_0000 : cnt_q + 32'h0000_0001;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_q <= 32'h0000_0000;
      tick_o <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      tick_o <= wrap && !clr_i;
    end
  end

endmodule : bia_tick

// >>> logic/bia_brake_alarm.sv
// Holding-brake interlock, fault flag and fault code logic with a Wishbone register slave.
//
// Added by the designer: the address map and register access over Wishbone.
`include "bia_params.svh"

module bia_brake_alarm
  import bia_pkg::*;
#(
  parameter int TICK_CYCLES = `BIA_TICK_CYCLES
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic drive_enable_n_i,
  input wire logic [13:0] motor_speed_i,
  input wire logic alarm_event_i,
  input wire logic [2:0] alarm_code_i,
  input wire logic alarm_encoder_i,
  input wire logic fault_clear_in_i,
  input wire logic [1:0] aux_func_i,
  output logic motor_drive_o,
  output logic brake_release_out_n_o,
  output logic [2:0] out_circuit_n_o,
  output logic fault_flag_out_o,
  output logic fault_code_bit0_o,
  output logic fault_code_bit1_o,
  output logic fault_code_bit2_o
);

  // --------------------------------------------------------------------------
  // Register slave
  // --------------------------------------------------------------------------
  bia_ctrl_type ctrl_q;
  logic [5:0] stop_delay_q;
  logic [13:0] speed_level_q;
  logic [13:0] max_speed_q;
  logic [6:0] wait_time_q;
  bia_state_type state_q;
  bia_state_type state_d;
  bia_fault_type fault_q;
  bia_fault_type fault_d;
  logic [6:0] cnt_q;
  logic [6:0] cnt_d;
  logic tick;
  logic brake_rel_q;

  wire wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire wb_done = wb_cyc_i && wb_stb_i && wb_ack_o;
  wire wb_wr = wb_done && wb_we_i && wb_sel_i[0];
  wire wb_wr_hi = wb_done && wb_we_i && wb_sel_i[1];
  wire hit_ctrl = (wb_adr_i == `BIA_CTRL_OFS);
  wire hit_stop = (wb_adr_i == `BIA_STOP_DELAY_OFS);
  wire hit_level = (wb_adr_i == `BIA_SPEED_LEVEL_OFS);
  wire hit_wait = (wb_adr_i == `BIA_WAIT_TIME_OFS);
  wire hit_max = (wb_adr_i == `BIA_MAX_SPEED_OFS);
  wire hit_stat = (wb_adr_i == `BIA_STATUS_OFS);

  wire [31:0] status_word = {22'h00_0000, state_q, fault_q, motor_drive_o, brake_rel_q, !drive_enable_n_i};
  wire [31:0] rd_word =
    hit_ctrl ? {26'h000_0000, ctrl_q} :
    hit_stop ? {26'h000_0000, stop_delay_q} :
    hit_level ? {18'h0_0000, speed_level_q} :
    hit_wait ? {25'h000_0000, wait_time_q} :
    hit_max ? {18'h0_0000, max_speed_q} :
    hit_stat ? status_word : 32'h0000_0000;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= wb_req;
      wb_dat_o <= wb_req ? rd_word : 32'h0000_0000;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_q <= `BIA_CTRL_RST;
      stop_delay_q <= `BIA_STOP_DELAY_RST;
      speed_level_q <= `BIA_SPEED_LEVEL_RST;
      wait_time_q <= `BIA_WAIT_TIME_RST;
      max_speed_q <= `BIA_MAX_SPEED_RST;
    end else begin
      if (wb_wr && hit_ctrl) ctrl_q <= wb_dat_i[5:0];
      if (wb_wr && hit_stop) stop_delay_q <= wb_dat_i[5:0];
      if (wb_wr && hit_wait) wait_time_q <= wb_dat_i[6:0];
      if (wb_wr && hit_level) speed_level_q[7:0] <= wb_dat_i[7:0];
      if (wb_wr_hi && hit_level) speed_level_q[13:8] <= wb_dat_i[13:8];
      if (wb_wr && hit_max) max_speed_q[7:0] <= wb_dat_i[7:0];
      if (wb_wr_hi && hit_max) max_speed_q[13:8] <= wb_dat_i[13:8];
    end
  end

  // --------------------------------------------------------------------------
  // Effective settings
  // --------------------------------------------------------------------------
  wire [5:0] stop_delay_eff = (stop_delay_q > `BIA_STOP_DELAY_MAX) ? `BIA_STOP_DELAY_MAX : stop_delay_q;
  wire [13:0] level_eff = (speed_level_q > max_speed_q) ? max_speed_q : speed_level_q;
  wire [6:0] wait_eff =
    (wait_time_q < `BIA_WAIT_TIME_MIN) ? `BIA_WAIT_TIME_MIN :
    (wait_time_q > `BIA_WAIT_TIME_MAX) ? `BIA_WAIT_TIME_MAX : wait_time_q;

  // --------------------------------------------------------------------------
  // Fault latch
  // --------------------------------------------------------------------------
  wire clear_ok = fault_clear_in_i && !fault_q.encoder;

  always_comb begin
    fault_d = fault_q;
    if (clear_ok) begin
      fault_d = '0;
    end
    if (alarm_event_i) begin
      fault_d.active = 1'b1;
      fault_d.encoder = fault_q.encoder || alarm_encoder_i;
      fault_d.code = alarm_code_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fault_q <= '0;
      fault_flag_out_o <= 1'b0;
      fault_code_bit0_o <= 1'b0;
      fault_code_bit1_o <= 1'b0;
      fault_code_bit2_o <= 1'b0;
    end else begin
      fault_q <= fault_d;
      fault_flag_out_o <= fault_d.active;
      fault_code_bit0_o <= fault_d.code[0];
      fault_code_bit1_o <= fault_d.code[1];
      fault_code_bit2_o <= fault_d.code[2];
    end
  end

  // --------------------------------------------------------------------------
  // Brake sequencer
  // --------------------------------------------------------------------------
  wire alarm_hit = alarm_event_i || fault_q.active;
  wire stopped = (motor_speed_i == 14'h0000);
  wire below_level = (motor_speed_i < level_eff);

  bia_tick #(
    .TICK_CYCLES(TICK_CYCLES)
  ) u_tick (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .clr_i(state_d != state_q),
    .tick_o(tick)
  );

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      BIA_OFF: begin
        if (!drive_enable_n_i && !alarm_hit) state_d = BIA_ON;
      end
      BIA_ON: begin
        if (alarm_hit || drive_enable_n_i) begin
          if (!stopped) state_d = BIA_MOVE;
          else if (alarm_hit || stop_delay_eff == 6'h00) state_d = BIA_OFF;
          else state_d = BIA_STOPDLY;
        end
      end
      BIA_STOPDLY: begin
        if (alarm_hit || cnt_q >= {1'b0, stop_delay_eff}) state_d = BIA_OFF;
      end
      BIA_MOVE: begin
        if (below_level || cnt_q >= wait_eff) state_d = BIA_OFF;
      end
    endcase
  end

  assign cnt_d = (state_d != state_q) ? 7'h00 : (tick ? cnt_q + 7'h01 : cnt_q);

  wire brake_rel_d = (state_d == BIA_ON) || (state_d == BIA_MOVE);
  wire drive_d = (state_d == BIA_ON) || (state_d == BIA_STOPDLY);
  wire [2:0] func_sel [3];
  wire [2:0] func_on = {aux_func_i, brake_rel_d};
  assign func_sel[0] = {1'b0, ctrl_q.brake_sel};
  assign func_sel[1] = {1'b0, ctrl_q.aux0_sel};
  assign func_sel[2] = {1'b0, ctrl_q.aux1_sel};

  logic [2:0] circuit_on;
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_circuit
      assign circuit_on[gi] = (func_on[0] && func_sel[0] == 3'(gi + 1)) ||
                              (func_on[1] && func_sel[1] == 3'(gi + 1)) ||
                              (func_on[2] && func_sel[2] == 3'(gi + 1));
    end
  endgenerate

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= BIA_OFF;
      cnt_q <= 7'h00;
      brake_rel_q <= 1'b0;
      motor_drive_o <= 1'b0;
      brake_release_out_n_o <= 1'b1;
      out_circuit_n_o <= 3'h7;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      brake_rel_q <= brake_rel_d;
      motor_drive_o <= drive_d;
      brake_release_out_n_o <= !brake_rel_d;
      out_circuit_n_o <= ~circuit_on;
    end
  end

  // --------------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------------
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_alarm_drive_off: assert property (alarm_event_i |=> !motor_drive_o)
    else $error("drive still on after alarm");
  a_servo_on_release: assert property (state_q == BIA_ON |-> motor_drive_o && !brake_release_out_n_o)
    else $error("servo on without drive or brake release");
  a_zero_delay_off: assert property (state_q == BIA_ON && drive_enable_n_i && stopped &&
    stop_delay_eff == 6'h00 |=> !motor_drive_o && brake_release_out_n_o)
    else $error("zero stop delay did not drop drive with brake");
  a_stop_delay_hold: assert property (state_q == BIA_STOPDLY |-> motor_drive_o && brake_release_out_n_o)
    else $error("stop delay phase outputs wrong");
  a_stop_delay_bound: assert property (state_q == BIA_STOPDLY |-> cnt_q <= {1'b0, stop_delay_eff})
    else $error("stop delay overran");
  a_move_level_end: assert property (state_q == BIA_MOVE && below_level |=> brake_release_out_n_o)
    else $error("brake not applied below speed level");
  a_move_wait_bound: assert property (state_q == BIA_MOVE |-> cnt_q <= wait_eff)
    else $error("brake wait time overran");
  a_move_no_drive: assert property (state_q == BIA_MOVE |-> !motor_drive_o && !brake_release_out_n_o)
    else $error("motion stop phase outputs wrong");
  a_fault_flag_set: assert property (alarm_event_i |=> fault_flag_out_o ##0
    {fault_code_bit2_o, fault_code_bit1_o, fault_code_bit0_o} == $past(alarm_code_i))
    else $error("fault flag or code not set");
  a_fault_clear_ok: assert property (fault_q.active && fault_clear_in_i && !fault_q.encoder &&
    !alarm_event_i |=> !fault_flag_out_o)
    else $error("fault clear ignored");
  a_encoder_sticky: assert property (fault_q.encoder |=> fault_flag_out_o)
    else $error("encoder alarm cleared without power cycle");
  a_route_first: assert property (ctrl_q.brake_sel == 2'd1 && $stable(ctrl_q) && brake_rel_q
    |-> !out_circuit_n_o[0])
    else $error("brake release not routed to first circuit");
  a_wb_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("bus access not acknowledged");
  a_wb_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("bus acknowledge held too long");
  a_off_brake_applied: assert property (state_q == BIA_OFF |-> brake_release_out_n_o && !motor_drive_o)
    else $error("brake released or drive on while off");
  a_fault_drive_off: assert property (fault_q.active |=> !motor_drive_o)
    else $error("drive on while alarm latched");
  a_delay_end_off: assert property (state_q == BIA_STOPDLY && cnt_q >= {1'b0, stop_delay_eff} |=>
    !motor_drive_o && brake_release_out_n_o)
    else $error("drive not removed at end of stop delay");
  a_wait_end_off: assert property (state_q == BIA_MOVE && cnt_q >= wait_eff |=> brake_release_out_n_o)
    else $error("brake not applied at end of wait time");
  a_level_clip: assert property (state_q == BIA_MOVE && speed_level_q > max_speed_q &&
    motor_speed_i < max_speed_q |=> brake_release_out_n_o)
    else $error("speed level not clipped to maximum speed");
  a_route_none: assert property (ctrl_q == 6'h00 && $stable(ctrl_q) |-> out_circuit_n_o == 3'h7)
    else $error("output circuit driven with no function routed");
  a_shared_or: assert property (aux_func_i[0] && ctrl_q.aux0_sel == 2'h2 |=> !out_circuit_n_o[1])
    else $error("shared output circuit lost a function");
  a_fault_flag_hold: assert property (fault_q.active && !clear_ok |=> fault_flag_out_o)
    else $error("fault flag dropped without clear");
  a_code_stable: assert property (!alarm_event_i && !fault_clear_in_i |=>
    $stable({fault_code_bit2_o, fault_code_bit1_o, fault_code_bit0_o}))
    else $error("fault code changed without alarm or clear");

  // --------------------------------------------------------------------------
  // Cover properties
  // --------------------------------------------------------------------------
  c_level_clip: cover property (state_q == BIA_MOVE && speed_level_q > max_speed_q);
  c_motion_stop: cover property (state_q == BIA_ON ##1 state_q == BIA_MOVE ##[1:200] state_q == BIA_OFF);
  c_stop_delay: cover property (state_q == BIA_STOPDLY ##1 state_q == BIA_OFF);
  c_fault_clear: cover property (fault_flag_out_o ##1 !fault_flag_out_o);
  c_encoder_hold: cover property (fault_q.encoder && fault_clear_in_i);

endmodule : bia_brake_alarm

// >>> verif/bia_host_model.sv
// Host controller model that gates servo on with the fault flag and guards fault clear.
module bia_host_model (
  input wire logic servo_req_i,
  input wire logic clear_req_i,
  input wire logic cause_gone_i,
  input wire logic fault_flag_i,
  output logic drive_enable_n_o,
  output logic fault_clear_o
);
  timeunit 1ns;
  timeprecision 1ps;
  assign drive_enable_n_o = ~servo_req_i | fault_flag_i;
  assign fault_clear_o = clear_req_i & cause_gone_i;
endmodule : bia_host_model

// >>> verif/testbench.sv
// Self-checking bench for the brake interlock and fault outputs.
`include "bia_params.svh"
module testbench;
  import bia_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i, rst_i, wb_cyc, wb_stb, wb_we, wb_ack_o, enable_n, clear_n, motor_drive_o, brake_n;
  logic servo_req, clear_req, cause_gone, alarm, enc, flag, b0, b1, b2;
  logic [7:0] wb_adr;
  logic [31:0] wb_dat, wb_dat_o;
  logic [13:0] speed;
  logic [2:0] code, circ;
  logic [1:0] aux;
  int fail_count = 0;
  int tests_run = 0;
  bia_brake_alarm #(.TICK_CYCLES(4)) u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
    .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(4'h3), .wb_dat_i(wb_dat), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .drive_enable_n_i(enable_n), .motor_speed_i(speed), .alarm_event_i(alarm),
    .alarm_code_i(code), .alarm_encoder_i(enc), .fault_clear_in_i(clear_n), .aux_func_i(aux),
    .motor_drive_o(motor_drive_o), .brake_release_out_n_o(brake_n), .out_circuit_n_o(circ),
    .fault_flag_out_o(flag), .fault_code_bit0_o(b0), .fault_code_bit1_o(b1), .fault_code_bit2_o(b2));
  bia_host_model u_host (.servo_req_i(servo_req), .clear_req_i(clear_req), .cause_gone_i(cause_gone),
    .fault_flag_i(flag), .drive_enable_n_o(enable_n), .fault_clear_o(clear_n));
  // --------------------------------------------------------------------------
  // Tasks
  // --------------------------------------------------------------------------
  task automatic conclude();
    $display("Checks %0d, mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : conclude
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic tk(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : tk
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] wd, output logic [31:0] rd);
    @(posedge clk_i);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= adr;
    wb_dat <= wd;
    do begin
      @(posedge clk_i);
    end while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we <= 1'b0;
  endtask : wb
  task automatic wr(input logic [7:0] adr, input logic [31:0] d);
    logic [31:0] r;
    wb(1'b1, adr, d, r);
  endtask : wr
  task automatic rd(input logic [7:0] adr, input logic [31:0] exp);
    logic [31:0] r;
    wb(1'b0, adr, 32'h0000_0000, r);
    check(r, exp);
  endtask : rd
  task automatic serv(input logic v, input int n);
    @(posedge clk_i);
    servo_req <= v;
    tk(n);
  endtask : serv
  task automatic fault_flag_out(input logic [2:0] c, input logic e);
    @(posedge clk_i);
    alarm <= 1'b1;
    code <= c;
    enc <= e;
    @(posedge clk_i);
    alarm <= 1'b0;
    enc <= 1'b0;
    tk(1);
  endtask : fault_flag_out
  // --------------------------------------------------------------------------
  // Clock, watchdog and scenarios
  // --------------------------------------------------------------------------
  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end
  initial begin
    repeat (20000) @(posedge clk_i);
    fail_count++;
    conclude();
  end
  initial begin
    {rst_i, cause_gone} = 2'b11;
    {wb_cyc, wb_stb, wb_we, servo_req, clear_req, alarm, enc} = '0;
    {wb_adr, wb_dat, speed, code, aux} = '0;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    tk(1);
    check(32'({brake_n, circ, flag}), 32'h0000_001E);
    rd(`BIA_STOP_DELAY_OFS, 32'h0000_0000);
    rd(`BIA_SPEED_LEVEL_OFS, 32'h0000_0064);
    rd(`BIA_WAIT_TIME_OFS, 32'h0000_0032);
    rd(8'h40, 32'h0000_0000);
    serv(1'b1, 3);
    check(32'({motor_drive_o, brake_n}), 32'h0000_0002);
    rd(`BIA_STATUS_OFS, 32'h0000_0107);
    for (int s = 0; s < 4; s++) begin
      wr(`BIA_CTRL_OFS, 32'(s));
      tk(2);
      check(32'(circ), (s == 0) ? 32'h0000_0007 : 32'(3'b111 & ~(3'b001 << (s - 1))));
    end
    wr(`BIA_CTRL_OFS, 32'h0000_000A);
    aux <= 2'b01;
    serv(1'b0, 2);
    check(32'({motor_drive_o, brake_n}), 32'h0000_0001);
    check(32'(circ), 32'h0000_0005);
    @(posedge clk_i);
    aux <= 2'b00;
    tk(2);
    check(32'(circ), 32'h0000_0007);
    wr(`BIA_STOP_DELAY_OFS, 32'h0000_0003);
    serv(1'b1, 3);
    serv(1'b0, 8);
    check(32'({motor_drive_o, brake_n}), 32'h0000_0003);
    tk(10);
    check(32'(motor_drive_o), 32'h0000_0000);
    @(posedge clk_i);
    speed <= 14'd500;
    serv(1'b1, 3);
    serv(1'b0, 2);
    check(32'({motor_drive_o, brake_n}), 32'h0000_0000);
    @(posedge clk_i);
    speed <= 14'd50;
    tk(3);
    check(32'(brake_n), 32'h0000_0001);
    wr(`BIA_WAIT_TIME_OFS, 32'h0000_000A);
    speed <= 14'd500;
    serv(1'b1, 3);
    serv(1'b0, 30);
    check(32'(brake_n), 32'h0000_0000);
    tk(15);
    check(32'(brake_n), 32'h0000_0001);
    wr(`BIA_MAX_SPEED_OFS, 32'h0000_00C8);
    wr(`BIA_SPEED_LEVEL_OFS, 32'h0000_03E8);
    speed <= 14'd250;
    serv(1'b1, 3);
    serv(1'b0, 3);
    check(32'(brake_n), 32'h0000_0000);
    @(posedge clk_i);
    speed <= 14'd150;
    tk(3);
    check(32'(brake_n), 32'h0000_0001);
    @(posedge clk_i);
    speed <= 14'd0;
    serv(1'b1, 3);
    fault_flag_out(3'd5, 1'b0);
    check(32'({motor_drive_o, flag, b2, b1, b0}), 32'h0000_000D);
    @(posedge clk_i);
    clear_req <= 1'b1;
    cause_gone <= 1'b0;
    tk(3);
    check(32'({motor_drive_o, flag}), 32'h0000_0001);
    @(posedge clk_i);
    cause_gone <= 1'b1;
    tk(3);
    check(32'({flag, b2, b1, b0}), 32'h0000_0000);
    @(posedge clk_i);
    clear_req <= 1'b0;
    speed <= 14'd500;
    tk(3);
    fault_flag_out(3'd2, 1'b0);
    check(32'({motor_drive_o, brake_n}), 32'h0000_0000);
    @(posedge clk_i);
    speed <= 14'd0;
    tk(3);
    check(32'(brake_n), 32'h0000_0001);
    @(posedge clk_i);
    clear_req <= 1'b1;
    tk(3);
    @(posedge clk_i);
    clear_req <= 1'b0;
    fault_flag_out(3'd3, 1'b1);
    @(posedge clk_i);
    clear_req <= 1'b1;
    tk(3);
    check(32'({flag, b2, b1, b0}), 32'h0000_000B);
    @(posedge clk_i);
    clear_req <= 1'b0;
    rst_i <= 1'b1;
    tk(2);
    @(posedge clk_i);
    rst_i <= 1'b0;
    tk(2);
    check(32'({flag, b2, b1, b0}), 32'h0000_0000);
    conclude();
  end
endmodule : testbench
